// File: include/ras_pkg.sv
// Package for the return-address stack: register map, field layout, reset values.
// Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
package ras_pkg;

	localparam int unsigned RAS_DEPTH    = 16;
	localparam int unsigned RAS_PC_W     = 15;
	localparam int unsigned RAS_PTR_W    = 5;
	localparam int unsigned RAS_IDX_W    = 4;
	localparam int unsigned RAS_ADDR_W   = 8;
	localparam int unsigned RAS_LOW_W    = 8;
	localparam int unsigned RAS_HIGH_W   = 7;

	localparam logic [4:0] RAS_PTR_EMPTY = 5'h1f;
	localparam logic [4:0] RAS_PTR_TOP   = 5'h0f;

	// Register byte offsets
	localparam logic [7:0] RAS_OFS_PTR    = 8'h00;
	localparam logic [7:0] RAS_OFS_LOW    = 8'h04;
	localparam logic [7:0] RAS_OFS_HIGH   = 8'h08;
	localparam logic [7:0] RAS_OFS_STATUS = 8'h0c;
	localparam logic [7:0] RAS_OFS_CFG    = 8'h10;

	// Status fields: write one to clear
	localparam int unsigned RAS_ST_OVF_BIT = 0;
	localparam int unsigned RAS_ST_UNF_BIT = 1;
	// Config fields
	localparam int unsigned RAS_CFG_RST_BIT = 0;
	localparam logic        RAS_CFG_RST_RST = 1'b0;

	localparam logic [1:0] RAS_RESP_OKAY   = 2'h0;
	localparam logic [1:0] RAS_RESP_SLVERR = 2'h2;

endpackage

// File: hw/ras_store.sv
// Sixteen-entry storage array for the return-address stack.
// Assumes one write port and an asynchronous read used by the owning module.
`timescale 1ns/1ns
module ras_store (
	// Clock
	input  wire logic                                 clk,
	// Write port
	input  wire logic                                 wr_en,
	input  wire logic [ras_pkg::RAS_IDX_W-1:0]        wr_idx,
	input  wire logic [ras_pkg::RAS_PC_W-1:0]         wr_data,
	// Read port
	input  wire logic [ras_pkg::RAS_IDX_W-1:0]        rd_idx,
	output logic      [ras_pkg::RAS_PC_W-1:0]         rd_data
);
	import ras_pkg::*;

	// private array
	// Private array, no path to program or data memory
	logic [RAS_PC_W-1:0] mem [RAS_DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	assign rd_data = mem[rd_idx];

endmodule // ras_store

// File: hw/ras_top.sv
// Return-address stack beside the program counter and sequencer, with AXI4-Lite registers.
// Assumes the sequencer gives one-cycle push/pop strobes and never both in one cycle.
//
// Notes on behaviour
// - Sixteen entries of fifteen bits each, enough for a full program counter.
// - Storage is private, not reachable from program or data address spaces.
// - Program counter pushed on call, call via working register, or interrupt entry.
// - Stack popped into program counter on any of the three return kinds.
// - Push and pop leave the program counter high latch untouched.
// - With fault reset off the stack wraps, seventeenth push overwrites the first.
// - Overflow and underflow flags set in either mode.
// - Pointer selects the top-entry pair; both halves read and write.
// - Pointer is five bits so overflow and underflow are visible.
// - Push increments then writes; pop reads then decrements.
// - After reset the stack is empty with the pointer at 0x1F.
// - Empty stack with fault reset on reads top pair as zero.
// - Fault reset enable set means overflow or underflow requests a device reset.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module ras_top (
	// Clock and reset
	input  wire logic                                 clk,
	input  wire logic                                 rst_b,
	// Sequencer events
	input  wire logic                                 call_push,
	input  wire logic                                 call_via_working_reg,
	input  wire logic                                 irq_push,
	input  wire logic                                 return_plain,
	input  wire logic                                 return_with_literal,
	input  wire logic                                 return_from_interrupt,
	input  wire logic [ras_pkg::RAS_PC_W-1:0]         pc_now,
	// Program counter reload
	output logic                                      pc_load,
	output logic      [ras_pkg::RAS_PC_W-1:0]         pc_restore,
	// Fault reset request
	output logic                                      stack_fault_reset,
	// AXI4-Lite write address
	input  wire logic                                 s_axi_awvalid,
	output logic                                      s_axi_awready,
	input  wire logic [ras_pkg::RAS_ADDR_W-1:0]       s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic                                 s_axi_wvalid,
	output logic                                      s_axi_wready,
	input  wire logic [31:0]                          s_axi_wdata,
	input  wire logic [3:0]                           s_axi_wstrb,
	// AXI4-Lite write response
	output logic                                      s_axi_bvalid,
	input  wire logic                                 s_axi_bready,
	output logic      [1:0]                           s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic                                 s_axi_arvalid,
	output logic                                      s_axi_arready,
	input  wire logic [ras_pkg::RAS_ADDR_W-1:0]       s_axi_araddr,
	// AXI4-Lite read data
	output logic                                      s_axi_rvalid,
	input  wire logic                                 s_axi_rready,
	output logic      [31:0]                          s_axi_rdata,
	output logic      [1:0]                           s_axi_rresp
);
	import ras_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [RAS_PTR_W-1:0]  ptr;
		logic                  ovf;
		logic                  unf;
		logic                  fault_en;
		logic                  pc_load;
		logic [RAS_PC_W-1:0]   pc_restore;
		logic                  fault_rst;
		logic                  aw_done;
		logic [RAS_ADDR_W-1:0] aw_addr;
		logic                  w_done;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
	} ras_state_s;

	ras_state_s st_q;
	ras_state_s st_d;

	logic                  mem_wr_en;
	logic [RAS_IDX_W-1:0]  mem_wr_idx;
	logic [RAS_PC_W-1:0]   mem_wr_data;
	logic [RAS_IDX_W-1:0]  mem_rd_idx;
	logic [RAS_PC_W-1:0]   mem_rd_data;

	// Register offset match, used by both read and write decode
	function automatic logic is_ofs(input logic [RAS_ADDR_W-1:0] a, input logic [RAS_ADDR_W-1:0] ofs);
		return {a[RAS_ADDR_W-1:2], 2'b00} == ofs;
	endfunction

	ras_store u_store (
		.clk     (clk),
		.wr_en   (mem_wr_en),
		.wr_idx  (mem_wr_idx),
		.wr_data (mem_wr_data),
		.rd_idx  (mem_rd_idx),
		.rd_data (mem_rd_data)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic                 push;
		logic                 pop;
		logic                 empty;
		logic [RAS_PTR_W-1:0] ptr_inc;
		logic [RAS_PC_W-1:0]  top_rd;
		logic                 do_wr;
		logic                 do_rd;
		logic                 hit_ptr;
		logic                 hit_low;
		logic                 hit_high;
		logic                 hit_st;
		logic                 hit_cfg;
		logic [RAS_PC_W-1:0]  entry_new;
		push      = 1'b0;
		pop       = 1'b0;
		empty     = 1'b0;
		ptr_inc   = '0;
		top_rd    = '0;
		do_wr     = 1'b0;
		do_rd     = 1'b0;
		hit_ptr   = 1'b0;
		hit_low   = 1'b0;
		hit_high  = 1'b0;
		hit_st    = 1'b0;
		hit_cfg   = 1'b0;
		entry_new = '0;
		st_d        = st_q;
		mem_wr_en   = 1'b0;
		mem_wr_idx  = st_q.ptr[RAS_IDX_W-1:0];
		mem_wr_data = pc_now;
		// Pointer 0x1f reads entry 15 through its low four bits
		mem_rd_idx  = st_q.ptr[RAS_IDX_W-1:0];

		// Load and fault are request pulses; the stack itself is never wiped by a fault
		st_d.pc_load   = 1'b0;
		st_d.fault_rst = 1'b0;

		push  = call_push | call_via_working_reg | irq_push;
		pop   = ~push & (return_plain | return_with_literal | return_from_interrupt);
		empty = st_q.ptr == RAS_PTR_EMPTY;

		top_rd = (empty && st_q.fault_en) ? '0 : mem_rd_data;

		// ****************************************
		// Stack operations; the high latch lives outside and is never touched here
		// ****************************************
		if (push) begin
			ptr_inc = empty ? 5'h00 : 5'((st_q.ptr + 5'h01) & 5'h0f);
			if (st_q.ptr == RAS_PTR_TOP) begin
				st_d.ovf = 1'b1;
				st_d.fault_rst = st_q.fault_en;
			end
			st_d.ptr    = ptr_inc;
			mem_wr_en   = 1'b1;
			mem_wr_idx  = ptr_inc[RAS_IDX_W-1:0];
			mem_wr_data = pc_now;
		end else if (pop) begin
			st_d.pc_load    = 1'b1;
			st_d.pc_restore = top_rd;
			if (empty) begin
				st_d.unf = 1'b1;
				st_d.fault_rst = st_q.fault_en;
			end
			// modulo sixteen
			// Circular underflow lands one below the top entry
			st_d.ptr = (st_q.ptr == 5'h00) ? RAS_PTR_EMPTY
				: (empty ? RAS_PTR_TOP - 5'h01 : st_q.ptr - 5'h01);
		end

		// ****************************************
		// AXI4-Lite write
		// ****************************************
		if (s_axi_awvalid && s_axi_awready) begin
			st_d.aw_done = 1'b1;
			st_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_d.w_done = 1'b1;
			st_d.w_data = s_axi_wdata;
			st_d.w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end

		// Writes yield to stack ops: software loses a cycle, but flags never race
		do_wr    = st_q.aw_done && st_q.w_done && !st_q.bvalid && !push && !pop;
		hit_ptr  = is_ofs(st_q.aw_addr, RAS_OFS_PTR);
		hit_low  = is_ofs(st_q.aw_addr, RAS_OFS_LOW);
		hit_high = is_ofs(st_q.aw_addr, RAS_OFS_HIGH);
		hit_st   = is_ofs(st_q.aw_addr, RAS_OFS_STATUS);
		hit_cfg  = is_ofs(st_q.aw_addr, RAS_OFS_CFG);
		entry_new = mem_rd_data;
		if (do_wr) begin
			st_d.aw_done = 1'b0;
			st_d.w_done  = 1'b0;
			st_d.bvalid  = 1'b1;
			st_d.bresp   = RAS_RESP_OKAY;
			if (hit_ptr && st_q.w_strb[0]) begin
				st_d.ptr = st_q.w_data[RAS_PTR_W-1:0];
			end else if ((hit_low || hit_high) && st_q.w_strb[0]) begin
				if (hit_low) begin
					entry_new[RAS_LOW_W-1:0] = st_q.w_data[RAS_LOW_W-1:0];
				end else begin
					entry_new[RAS_PC_W-1:RAS_LOW_W] = st_q.w_data[RAS_HIGH_W-1:0];
				end
				mem_wr_en   = 1'b1;
				mem_wr_data = entry_new;
			end else if (hit_st && st_q.w_strb[0]) begin
				// Write one clears; a same-cycle event still sets, as stack ops block this path
				if (st_q.w_data[RAS_ST_OVF_BIT]) begin
					st_d.ovf = 1'b0;
				end
				if (st_q.w_data[RAS_ST_UNF_BIT]) begin
					st_d.unf = 1'b0;
				end
			end else if (hit_cfg && st_q.w_strb[0]) begin
				st_d.fault_en = st_q.w_data[RAS_CFG_RST_BIT];
			end else if (!(hit_ptr || hit_low || hit_high || hit_st || hit_cfg)) begin
				st_d.bresp = RAS_RESP_SLVERR;
			end
		end

		// ****************************************
		// AXI4-Lite read
		// ****************************************
		if (s_axi_rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end
		do_rd = s_axi_arvalid && s_axi_arready;
		if (do_rd) begin
			st_d.rvalid = 1'b1;
			st_d.rresp  = RAS_RESP_OKAY;
			st_d.rdata  = '0;
			if (is_ofs(s_axi_araddr, RAS_OFS_PTR)) begin
				st_d.rdata[RAS_PTR_W-1:0] = st_q.ptr;
			end else if (is_ofs(s_axi_araddr, RAS_OFS_LOW)) begin
				st_d.rdata[RAS_LOW_W-1:0] = top_rd[RAS_LOW_W-1:0];
			end else if (is_ofs(s_axi_araddr, RAS_OFS_HIGH)) begin
				st_d.rdata[RAS_HIGH_W-1:0] = top_rd[RAS_PC_W-1:RAS_LOW_W];
			end else if (is_ofs(s_axi_araddr, RAS_OFS_STATUS)) begin
				st_d.rdata[RAS_ST_OVF_BIT] = st_q.ovf;
				st_d.rdata[RAS_ST_UNF_BIT] = st_q.unf;
			end else if (is_ofs(s_axi_araddr, RAS_OFS_CFG)) begin
				st_d.rdata[RAS_CFG_RST_BIT] = st_q.fault_en;
			end else begin
				st_d.rresp = RAS_RESP_SLVERR;
			end
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q          <= '0;
			st_q.ptr      <= RAS_PTR_EMPTY;
			st_q.fault_en <= RAS_CFG_RST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign pc_load           = st_q.pc_load;
	assign pc_restore        = st_q.pc_restore;
	assign stack_fault_reset = st_q.fault_rst;
	assign s_axi_awready     = ~st_q.aw_done;
	assign s_axi_wready      = ~st_q.w_done;
	assign s_axi_bvalid      = st_q.bvalid;
	assign s_axi_bresp       = st_q.bresp;
	// Read address is accepted only while no answer is pending
	assign s_axi_arready     = ~st_q.rvalid;
	assign s_axi_rvalid      = st_q.rvalid;
	assign s_axi_rdata       = st_q.rdata;
	assign s_axi_rresp       = st_q.rresp;

endmodule // ras_top

// File: tb/ras_seq_model.sv
// Sequencer stand-in: issues push and pop strobes with a program counter.
// Assumes the bench calls fire() once for each instruction event.
`timescale 1ns/1ns
module ras_seq_model (
	// Clock
	input  wire logic        clk,
	// Strobes and program counter
	output logic      [5:0]  ev,
	output logic      [14:0] pc_now
);
	initial begin
		ev     = 6'h00;
		pc_now = 15'h0000;
	end
	task automatic fire(input int k, input logic [14:0] v);
		@(posedge clk);
		ev     <= 6'h01 << k;
		pc_now <= v;
		@(posedge clk);
		ev     <= 6'h00;
		// Stale value would hide a late sample
		pc_now <= ~v;
	endtask
endmodule // ras_seq_model

// File: tb/ras_checker.sv
// Port checker for the return-address stack.
// Assumes a bind from the bench top; single clock domain.
`timescale 1ns/1ns
module ras_checker (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_b,
	// Sequencer
	input wire logic        call_push,
	input wire logic        call_via_working_reg,
	input wire logic        irq_push,
	input wire logic        return_plain,
	input wire logic        return_with_literal,
	input wire logic        return_from_interrupt,
	input wire logic        pc_load,
	input wire logic [14:0] pc_restore,
	input wire logic        stack_fault_reset,
	// Register bus
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	wire logic psh = call_push | call_via_working_reg | irq_push;
	wire logic pop = return_plain | return_with_literal | return_from_interrupt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_pop_loads: assert property (pop && !psh |=> pc_load) else $error("pop gave no load");
	a_push_noload: assert property (psh |=> !pc_load) else $error("push gave a load");
	a_load_cause: assert property (pc_load |-> $past(pop)) else $error("load without pop");
	a_restore_hold: assert property (!pc_load |-> $stable(pc_restore)) else $error("restore moved");
	a_fault_pulse: assert property (stack_fault_reset |=> !stack_fault_reset || $past(psh | pop))
		else $error("fault held");
	a_fault_cause: assert property (stack_fault_reset |-> $past(psh | pop)) else $error("fault no cause");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("response dropped");
	a_b_cause: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready)) else $error("response no write");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open early");
endmodule // ras_checker

// File: tb/ras_top_test.sv
// Self-checking bench for the return-address stack against an integer model.
// Assumes ras_top, ras_seq_model and ras_checker are compiled first.
`timescale 1ns/1ns
module ras_top_test;
	import ras_pkg::*;
	logic        clk, rst_b, pc_load, stack_fault_reset;
	logic [5:0]  ev;
	logic [14:0] pc_now, pc_restore;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          err_total, checks, seed, ptr, mem [16];
	bit          ovf, unf, en;

	ras_seq_model seq (.clk, .ev, .pc_now);
	ras_top dut (.clk, .rst_b, .call_push(ev[0]), .call_via_working_reg(ev[1]), .irq_push(ev[2]),
		.return_plain(ev[3]), .return_with_literal(ev[4]), .return_from_interrupt(ev[5]), .pc_now, .pc_load,
		.pc_restore, .stack_fault_reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		err_total++;
		finish_test;
	end

	// ****************************************
	// Compare and bus tasks
	// ****************************************
	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %0t reg got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_pc(input logic [14:0] g, input logic [14:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %0t pc got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr  <= a;
		s_axi_wvalid  <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_bready  <= 1'b1;
		#1;
		while (s_axi_awvalid || s_axi_wvalid) begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid)
			@(posedge clk);
		s_axi_bready <= 1'b0;
		chk_reg(32'(s_axi_bresp), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr  <= a;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		// Late ready exercises the hold of read data
		if ($random(seed) & 1)
			@(posedge clk);
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk_reg(32'(s_axi_rresp), 32'(er));
		if (er == RAS_RESP_OKAY)
			chk_reg(s_axi_rdata, e);
	endtask

	// ****************************************
	// Stack model
	// ****************************************
	function automatic int top_val();
		return (ptr == 31 && en) ? 0 : mem[ptr % 16];
	endfunction
	task automatic push(input int k, input logic [14:0] v);
		seq.fire(k, v);
		#1;
		chk_reg(32'(pc_load), 32'h0);
		chk_reg(32'(stack_fault_reset), 32'(ptr == 15 && en));
		ovf |= (ptr == 15);
		ptr = (ptr == 31) ? 0 : (ptr + 1) % 16;
		mem[ptr] = v;
	endtask
	task automatic pop(input int k);
		seq.fire(k + 3, 15'($random(seed)));
		#1;
		chk_pc(pc_restore, 15'(top_val()));
		chk_reg(32'(pc_load), 32'h1);
		chk_reg(32'(stack_fault_reset), 32'(ptr == 31 && en));
		unf |= (ptr == 31);
		ptr = (ptr == 0) ? 31 : (ptr == 31) ? 14 : ptr - 1;
	endtask
	task automatic finish_test;
		$display("Mismatches %0d of %0d checks", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		seed = 19;
		ptr = 31;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		rst_b = 1'b0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		rd(RAS_OFS_PTR, 32'h1f, RAS_RESP_OKAY);
		rd(8'h14, 32'h0, RAS_RESP_SLVERR);
		wr(8'h14, 32'h1, RAS_RESP_SLVERR);
		for (int i = 0; i < 17; i++)
			push(i % 3, 15'($random(seed)));
		rd(RAS_OFS_PTR, ptr, RAS_RESP_OKAY);
		rd(RAS_OFS_STATUS, {unf, ovf}, RAS_RESP_OKAY);
		for (int i = 0; i < 18; i++)
			pop(i % 3);
		rd(RAS_OFS_STATUS, {unf, ovf}, RAS_RESP_OKAY);
		wr(RAS_OFS_STATUS, 32'h3, RAS_RESP_OKAY);
		{unf, ovf} = 2'h0;
		rd(RAS_OFS_STATUS, 32'h0, RAS_RESP_OKAY);
		wr(RAS_OFS_PTR, 32'h5, RAS_RESP_OKAY);
		ptr = 5;
		rd(RAS_OFS_LOW, top_val() & 8'hff, RAS_RESP_OKAY);
		rd(RAS_OFS_HIGH, top_val() >> 8, RAS_RESP_OKAY);
		wr(RAS_OFS_LOW, 32'h5a, RAS_RESP_OKAY);
		wr(RAS_OFS_HIGH, 32'h33, RAS_RESP_OKAY);
		mem[5] = 15'h335a;
		pop(0);
		wr(RAS_OFS_CFG, 32'h1, RAS_RESP_OKAY);
		en = 1'b1;
		wr(RAS_OFS_PTR, 32'h1f, RAS_RESP_OKAY);
		ptr = 31;
		rd(RAS_OFS_LOW, 32'h0, RAS_RESP_OKAY);
		pop(1);
		push(2, 15'($random(seed)));
		push(0, 15'($random(seed)));
		rd(RAS_OFS_STATUS, {unf, ovf}, RAS_RESP_OKAY);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		ptr = 31;
		{en, ovf, unf} = 3'h0;
		rd(RAS_OFS_PTR, 32'h1f, RAS_RESP_OKAY);
		rd(RAS_OFS_STATUS, {unf, ovf}, RAS_RESP_OKAY);
		rd(RAS_OFS_CFG, 32'h0, RAS_RESP_OKAY);
		finish_test;
	end
endmodule // ras_top_test

bind ras_top ras_checker chk (.clk, .rst_b, .call_push, .call_via_working_reg, .irq_push, .return_plain,
	.return_with_literal, .return_from_interrupt, .pc_load, .pc_restore, .stack_fault_reset, .s_axi_awready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
